// ### src/uie_pkg.sv
// Shared constants of the IN-endpoint interrupt enable block.
// Assumes a 32-bit AXI4-Lite register bus, one aligned word per register.
package uie_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] UIE_IDX_MASK = 8'h07;
   localparam logic [7:0] UIE_IDX_STAT = 8'h08;
   localparam logic [7:0] UIE_IDX_CLR = 8'h09;
   localparam int UIE_ADDR_W = 8;
   localparam logic [7:0] UIE_ADDR_MASK = 8'(UIE_IDX_MASK * 4);
   localparam logic [7:0] UIE_ADDR_STAT = 8'(UIE_IDX_STAT * 4);
   localparam logic [7:0] UIE_ADDR_CLR = 8'(UIE_IDX_CLR * 4);

   // Field layout shared by mask, status and clear
   localparam int UIE_EP_NUM = 4;
   localparam int UIE_BIT_CTRL = 0;
   localparam int UIE_BIT_IN1 = 1;
   localparam int UIE_BIT_IN2 = 2;
   localparam int UIE_BIT_IN3 = 3;
   localparam logic [3:0] UIE_MASK_RST = 4'hF;
   localparam logic [3:0] UIE_STAT_RST = 4'h0;

   // AXI response codes
   localparam logic [1:0] UIE_RESP_OKAY = 2'h0;
   localparam logic [1:0] UIE_RESP_SLVERR = 2'h2;

   // Read channel states, Gray coded along idle, look-up, data
   typedef enum logic [1:0] {
      UIE_RD_IDLE = 2'h0,
      UIE_RD_LOOK = 2'h1,
      UIE_RD_DATA = 2'h3
   } uie_rd_state_e;

endpackage

// ### src/uie_evt_qual.sv
// Completion-event qualifier for one IN endpoint.
// Assumes packet, error and handshake strobes are one-cycle pulses on CLK.
`timescale 1ns/1ps
`default_nettype none
module uie_evt_qual
   import uie_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic pkt_done,
   input wire logic pkt_err,
   input wire logic hs_ack,
   output logic evt
);

   logic armed_q;
   logic evt_q;

   // Armed once a whole clean packet has gone out; an error disarms it
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         armed_q <= 1'b0;
      end else if (pkt_done && !pkt_err) begin
         armed_q <= 1'b1;
      end else if (pkt_err || hs_ack) begin
         armed_q <= 1'b0;
      end
   end

   // Event only when the host handshake follows a clean packet
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         evt_q <= 1'b0;
      end else begin
         evt_q <= armed_q && hs_ack && !pkt_err;
      end
   end

   assign evt = evt_q;

   sequence clean_sent;
      pkt_done && !pkt_err;
   endsequence

   sequence acked;
      hs_ack && !pkt_err && !pkt_done;
   endsequence

   chk_evt_cause: assert property (@(posedge clk) disable iff (!rst_b)
      evt_q |-> $past(armed_q) && $past(hs_ack) && !$past(pkt_err))
      else $error("endpoint event without clean packet and handshake");

   chk_evt_follow: assert property (@(posedge clk) disable iff (!rst_b)
      clean_sent ##1 acked |=> evt_q)
      else $error("clean packet and handshake raised no event");

endmodule
`default_nettype wire

// ### src/uie_axil_slave.sv
// AXI4-Lite slave front end: handshakes, address hold and response timing.
// Assumes the register file answers combinationally within the same cycle.
`timescale 1ns/1ps
`default_nettype none
module uie_axil_slave
   import uie_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [UIE_ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [UIE_ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wr_fire,
   output logic [UIE_ADDR_W-1:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_ok,
   output logic rd_fire,
   output logic [UIE_ADDR_W-1:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);

   logic aw_held_q;
   logic w_held_q;
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic [UIE_ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   uie_rd_state_e rd_st_q;
   logic [UIE_ADDR_W-1:0] araddr_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic arready_q;
   logic rvalid_q;

   // Write fires once both halves are held and no response is pending
   assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
   assign wr_addr = awaddr_q;
   assign wr_data = wdata_q;
   assign wr_strb = wstrb_q;

   // Address and data are taken independently, in either order
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         aw_held_q <= 1'b0;
         awready_q <= 1'b0;
         awaddr_q <= '0;
      end else if (awvalid && awready_q) begin
         aw_held_q <= 1'b1;
         awready_q <= 1'b0;
         awaddr_q <= awaddr;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end else if (!aw_held_q && !bvalid_q) begin
         awready_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         w_held_q <= 1'b0;
         wready_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (wvalid && wready_q) begin
         w_held_q <= 1'b1;
         wready_q <= 1'b0;
         wdata_q <= wdata;
         wstrb_q <= wstrb;
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end else if (!w_held_q && !bvalid_q) begin
         wready_q <= 1'b1;
      end
   end

   // Response stands until the master takes it; ready stays low meanwhile
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         bvalid_q <= 1'b0;
         bresp_q <= UIE_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_ok ? UIE_RESP_OKAY : UIE_RESP_SLVERR;
      end else if (bvalid_q && bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign rd_fire = (rd_st_q == UIE_RD_LOOK);
   assign rd_addr = araddr_q;

   // Read: take address, look up, hold data; ready and valid are own flops
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rd_st_q <= UIE_RD_IDLE;
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         araddr_q <= '0;
         rdata_q <= '0;
         rresp_q <= UIE_RESP_OKAY;
      end else begin
         case (rd_st_q)
            UIE_RD_IDLE: begin
               if (arvalid) begin
                  araddr_q <= araddr;
                  arready_q <= 1'b0;
                  rd_st_q <= UIE_RD_LOOK;
               end
            end
            UIE_RD_LOOK: begin
               rdata_q <= rd_data;
               rresp_q <= rd_ok ? UIE_RESP_OKAY : UIE_RESP_SLVERR;
               rvalid_q <= 1'b1;
               rd_st_q <= UIE_RD_DATA;
            end
            UIE_RD_DATA: begin
               if (rready) begin
                  rvalid_q <= 1'b0;
                  arready_q <= 1'b1;
                  rd_st_q <= UIE_RD_IDLE;
               end
            end
            default: begin
               arready_q <= 1'b1;
               rvalid_q <= 1'b0;
               rd_st_q <= UIE_RD_IDLE;
            end
         endcase
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   sequence both_held;
      aw_held_q && w_held_q && !bvalid_q;
   endsequence

   chk_write_resp: assert property (@(posedge clk) disable iff (!rst_b)
      both_held |=> bvalid_q ##1 (bvalid_q || $past(bready)))
      else $error("write response missing after both halves held");

endmodule
`default_nettype wire

// ### src/uie_irq_top.sv
// IN-endpoint interrupt enable block with event status and one IRQ line.
// Assumes endpoint strobes come from logic on CLK; registers over AXI4-Lite.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module uie_irq_top
   import uie_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [UIE_ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [UIE_ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [2:0] IN_PKT_SENT,
   input wire logic [2:0] IN_PKT_ERR,
   input wire logic [2:0] IN_HS_ACK,
   input wire logic CTRL_EP_EVT,
   output logic IRQ
);

   logic wr_fire;
   logic [UIE_ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_ok;
   logic rd_fire;
   logic [UIE_ADDR_W-1:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_ok;
   logic [2:0] in_evt;
   logic [UIE_EP_NUM-1:0] evt_all;
   logic [UIE_EP_NUM-1:0] mask_q;
   logic [UIE_EP_NUM-1:0] stat_q;
   logic [UIE_EP_NUM-1:0] stat_d;
   logic [UIE_EP_NUM-1:0] clr_hit;
   logic irq_q;
   logic rd_is_mask_q;

   uie_axil_slave u_bus (
      .clk(CLK),
      .rst_b(RST_B),
      .awaddr(S_AXI_AWADDR),
      .awvalid(S_AXI_AWVALID),
      .awready(S_AXI_AWREADY),
      .wdata(S_AXI_WDATA),
      .wstrb(S_AXI_WSTRB),
      .wvalid(S_AXI_WVALID),
      .wready(S_AXI_WREADY),
      .bresp(S_AXI_BRESP),
      .bvalid(S_AXI_BVALID),
      .bready(S_AXI_BREADY),
      .araddr(S_AXI_ARADDR),
      .arvalid(S_AXI_ARVALID),
      .arready(S_AXI_ARREADY),
      .rdata(S_AXI_RDATA),
      .rresp(S_AXI_RRESP),
      .rvalid(S_AXI_RVALID),
      .rready(S_AXI_RREADY),
      .wr_fire(wr_fire),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ok(wr_ok),
      .rd_fire(rd_fire),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   // One qualifier per IN endpoint 1..3
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_in_ep
         uie_evt_qual u_qual (
            .clk(CLK),
            .rst_b(RST_B),
            .pkt_done(IN_PKT_SENT[gi]),
            .pkt_err(IN_PKT_ERR[gi]),
            .hs_ack(IN_HS_ACK[gi]),
            .evt(in_evt[gi])
         );
      end
   endgenerate

   // Bit 0 is the control endpoint, bits 3..1 the IN endpoints
   assign evt_all = {in_evt, CTRL_EP_EVT};

   // Writes land only on mapped words; the low byte lane carries the fields
   assign wr_ok = (wr_addr == UIE_ADDR_MASK) || (wr_addr == UIE_ADDR_CLR)
      || (wr_addr == UIE_ADDR_STAT);

   // Enable mask: only the four low bits are stored
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         mask_q <= UIE_MASK_RST;
      end else if (wr_fire && wr_strb[0] && wr_addr == UIE_ADDR_MASK) begin
         mask_q <= wr_data[UIE_EP_NUM-1:0];
      end
   end

   // Write-one-to-clear strobe; the status word itself is read only
   assign clr_hit = (wr_fire && wr_strb[0] && wr_addr == UIE_ADDR_CLR)
      ? wr_data[UIE_EP_NUM-1:0] : '0;

   // Sticky status; a new event wins over a clear in the same cycle
   always_comb begin
      stat_d = (stat_q & ~clr_hit) | evt_all;
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         stat_q <= UIE_STAT_RST;
      end else begin
         stat_q <= stat_d;
      end
   end

   // Level interrupt from a flop: costs one cycle but keeps IRQ glitch free
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(stat_q & mask_q);
      end
   end

   assign IRQ = irq_q;

   // Read mux; upper bits are always zero and the clear word reads zero
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_ok = 1'b1;
      case (rd_addr)
         UIE_ADDR_MASK: rd_data[UIE_EP_NUM-1:0] = mask_q;
         UIE_ADDR_STAT: rd_data[UIE_EP_NUM-1:0] = stat_q;
         UIE_ADDR_CLR: rd_data = 32'h0000_0000;
         default: rd_ok = 1'b0;
      endcase
   end

   // Helper for the read-back check only
   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         rd_is_mask_q <= 1'b0;
      end else if (rd_fire) begin
         rd_is_mask_q <= (rd_addr == UIE_ADDR_MASK);
      end
   end

   chk_ep3_pass: assert property (@(posedge CLK) disable iff (!RST_B)
      (stat_q[UIE_BIT_IN3] && mask_q[UIE_BIT_IN3]) |=> IRQ)
      else $error("enabled endpoint 3 status did not raise IRQ");

   chk_ep2_block: assert property (@(posedge CLK) disable iff (!RST_B)
      (stat_q[UIE_BIT_IN2] && !mask_q[UIE_BIT_IN2]
       && (stat_q & mask_q) == 4'h0) |=> !IRQ)
      else $error("masked endpoint 2 status raised IRQ");

   chk_ep1_setwin: assert property (@(posedge CLK) disable iff (!RST_B)
      (in_evt[0] && clr_hit[UIE_BIT_IN1]) |=> stat_q[UIE_BIT_IN1] ##1
      (IRQ || !$past(mask_q[UIE_BIT_IN1])))
      else $error("endpoint 1 event lost against clear");

   chk_mask_reset: assert property (@(posedge CLK) disable iff (!RST_B)
      !$past(RST_B) |-> mask_q == UIE_MASK_RST && !IRQ)
      else $error("enables not all set after reset");

   chk_ctrl_pass: assert property (@(posedge CLK) disable iff (!RST_B)
      (stat_q[UIE_BIT_CTRL] && mask_q[UIE_BIT_CTRL]) |=> IRQ)
      else $error("enabled control endpoint status did not raise IRQ");

   chk_mask_upper: assert property (@(posedge CLK) disable iff (!RST_B)
      (S_AXI_RVALID && rd_is_mask_q) |-> S_AXI_RDATA[31:4] == 28'h0)
      else $error("upper mask bits read non-zero");

   // Register-write steps shared by the mask checks
   sequence mask_write;
      wr_fire && wr_strb[0] && wr_addr == UIE_ADDR_MASK;
   endsequence

   sequence mask_quiet;
      !(wr_fire && wr_strb[0] && wr_addr == UIE_ADDR_MASK);
   endsequence

   chk_mask_write: assert property (@(posedge CLK) disable iff (!RST_B)
      mask_write |=> mask_q == $past(wr_data[UIE_EP_NUM-1:0]))
      else $error("mask did not take the low written bits");

   chk_mask_hold: assert property (@(posedge CLK) disable iff (!RST_B)
      mask_quiet |=> $stable(mask_q))
      else $error("mask changed without a mask write");

   // Pass and block per enable bit; blocking needs no other enabled status
   chk_ep3_block: assert property (@(posedge CLK) disable iff (!RST_B)
      (stat_q[UIE_BIT_IN3] && !mask_q[UIE_BIT_IN3]
       && (stat_q & mask_q) == 4'h0) |=> !IRQ)
      else $error("masked endpoint 3 status raised IRQ");

   chk_ep2_pass: assert property (@(posedge CLK) disable iff (!RST_B)
      (stat_q[UIE_BIT_IN2] && mask_q[UIE_BIT_IN2]) |=> IRQ)
      else $error("enabled endpoint 2 status did not raise IRQ");

   chk_ep1_pass: assert property (@(posedge CLK) disable iff (!RST_B)
      (stat_q[UIE_BIT_IN1] && mask_q[UIE_BIT_IN1]) |=> IRQ)
      else $error("enabled endpoint 1 status did not raise IRQ");

   chk_ep1_block: assert property (@(posedge CLK) disable iff (!RST_B)
      (stat_q[UIE_BIT_IN1] && !mask_q[UIE_BIT_IN1]
       && (stat_q & mask_q) == 4'h0) |=> !IRQ)
      else $error("masked endpoint 1 status raised IRQ");

   chk_ctrl_block: assert property (@(posedge CLK) disable iff (!RST_B)
      (stat_q[UIE_BIT_CTRL] && !mask_q[UIE_BIT_CTRL]
       && (stat_q & mask_q) == 4'h0) |=> !IRQ)
      else $error("masked control endpoint status raised IRQ");

   // IRQ is the registered OR of the enabled status bits
   chk_irq_rise: assert property (@(posedge CLK) disable iff (!RST_B)
      ((stat_q & mask_q) != 4'h0) |=> IRQ)
      else $error("enabled status did not raise IRQ");

   chk_irq_fall: assert property (@(posedge CLK) disable iff (!RST_B)
      ((stat_q & mask_q) == 4'h0) |=> !IRQ)
      else $error("IRQ high without enabled status");

   // Read-back of each mapped word, then the unmapped-write error; the look-up lands in RDATA one edge later
   chk_rd_mask_value: assert property (@(posedge CLK) disable iff (!RST_B)
      (rd_fire && rd_addr == UIE_ADDR_MASK) |=> S_AXI_RDATA == {28'h0, $past(mask_q)})
      else $error("mask read-back differs from the mask");

   chk_rd_stat_value: assert property (@(posedge CLK) disable iff (!RST_B)
      (rd_fire && rd_addr == UIE_ADDR_STAT) |=> S_AXI_RDATA == {28'h0, $past(stat_q)})
      else $error("status read-back differs from the status");

   chk_rd_clr_zero: assert property (@(posedge CLK) disable iff (!RST_B)
      (rd_fire && rd_addr == UIE_ADDR_CLR) |=> S_AXI_RDATA == 32'h0000_0000)
      else $error("clear word did not read zero");

   chk_wr_unmapped: assert property (@(posedge CLK) disable iff (!RST_B)
      (wr_fire && !wr_ok) |=> S_AXI_BRESP == UIE_RESP_SLVERR)
      else $error("unmapped write not answered with an error");

   // Status bits: set by events, cleared by lone clears, sticky otherwise
   generate
      for (gi = 0; gi < UIE_EP_NUM; gi++) begin : g_stat_chk
         chk_stat_set: assert property (@(posedge CLK) disable iff (!RST_B)
            evt_all[gi] |=> stat_q[gi])
            else $error("event did not set its status bit");

         chk_stat_clear: assert property (@(posedge CLK) disable iff (!RST_B)
            (clr_hit[gi] && !evt_all[gi]) |=> !stat_q[gi])
            else $error("cleared status bit stayed set");

         chk_stat_sticky: assert property (@(posedge CLK) disable iff (!RST_B)
            (stat_q[gi] && !clr_hit[gi]) |=> stat_q[gi])
            else $error("status bit dropped without a clear");

         chk_stat_cause: assert property (@(posedge CLK) disable iff (!RST_B)
            (!stat_q[gi] && !evt_all[gi]) |=> !stat_q[gi])
            else $error("status bit set without an event");
      end
   endgenerate

   // Each IN endpoint end to end: clean packet, handshake, status, IRQ
   generate
      for (gi = 0; gi < 3; gi++) begin : g_in_chk
         sequence clean_then_ack;
            (IN_PKT_SENT[gi] && !IN_PKT_ERR[gi])
               ##1 (IN_HS_ACK[gi] && !IN_PKT_ERR[gi] && !IN_PKT_SENT[gi]);
         endsequence

         chk_in_to_stat: assert property (@(posedge CLK) disable iff (!RST_B)
            clean_then_ack |=> ##1 stat_q[gi+1])
            else $error("clean packet and handshake never reached status");

         chk_in_irq: assert property (@(posedge CLK) disable iff (!RST_B)
            clean_then_ack |=> ##2 (IRQ || !$past(mask_q[gi+1])))
            else $error("enabled endpoint completion did not raise IRQ");

         chk_in_err_drop: assert property (@(posedge CLK) disable iff (!RST_B)
            IN_PKT_ERR[gi] |=> !in_evt[gi])
            else $error("errored packet raised an endpoint event");
      end
   endgenerate

endmodule
`default_nettype wire

// ### sim/usb_in_endpoint_irq_enable_tb.sv
// Self-checking bench of the IN-endpoint interrupt enable block.
// Assumes uie_pkg and uie_irq_top are compiled first; one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module usb_in_endpoint_irq_enable_tb
   import uie_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [2:0] sent = 3'h0;
   logic [2:0] err = 3'h0;
   logic [2:0] ack = 3'h0;
   logic ctrl = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, m, s, c;
   int num_errors = 0;
   int comparisons = 0;
   int seed = 32'h1946;

   // Half period 25 ns
   always #25 clk = ~clk;

   uie_irq_top uie_irq_top_inst (
      .CLK(clk), .RST_B(rst_b),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .IN_PKT_SENT(sent), .IN_PKT_ERR(err), .IN_HS_ACK(ack), .CTRL_EP_EVT(ctrl), .IRQ(irq)
   );

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
                     input logic [1:0] er);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= st;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      chk("bresp", {30'h0, er}, {30'h0, bresp});
      bready <= 1'b0;
   endtask

   // Read and compare data and response
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er,
                     input string what);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      chk(what, exp, rdata);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
      rready <= 1'b0;
   endtask

   task automatic ev(input logic [2:0] sv, input logic [2:0] ev_err, input logic [2:0] kv,
                     input logic cv);
      @(posedge clk);
      sent <= sv;
      err <= ev_err;
      ack <= kv;
      ctrl <= cv;
   endtask

   // One clean completion on endpoint ep, then let status and IRQ settle
   task automatic fire(input int ep);
      if (ep == 0) begin
         ev(3'h0, 3'h0, 3'h0, 1'b1);
      end else begin
         ev(3'(1 << (ep - 1)), 3'h0, 3'h0, 1'b0);
         ev(3'h0, 3'h0, 3'(1 << (ep - 1)), 1'b0);
      end
      ev(3'h0, 3'h0, 3'h0, 1'b0);
      repeat (4) @(posedge clk);
   endtask

   function automatic logic [31:0] exp_irq(input logic [3:0] mk, input logic [3:0] st);
      return {31'h0, |(mk & st)};
   endfunction

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Whole run needs about 500 cycles
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      summarize();
   end

   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(UIE_ADDR_MASK, {28'h0, UIE_MASK_RST}, UIE_RESP_OKAY, "mask reset");
      rd(UIE_ADDR_STAT, 32'h0, UIE_RESP_OKAY, "status reset");
      chk("irq reset", 32'h0, {31'h0, irq});
      wr(8'h40, 32'hFFFFFFFF, 4'hF, UIE_RESP_SLVERR);
      rd(8'h40, 32'h0, UIE_RESP_SLVERR, "unmapped");
      rd(UIE_ADDR_CLR, 32'h0, UIE_RESP_OKAY, "clear reads zero");
      wr(UIE_ADDR_MASK, 32'h0, 4'hE, UIE_RESP_OKAY);
      rd(UIE_ADDR_MASK, 32'hF, UIE_RESP_OKAY, "mask strobe off");
      $display("test reset_map done");
      // Each endpoint with its enable off, then on; other bits random
      for (int en = 0; en < 2; en++) begin
         for (int ep = 0; ep < 4; ep++) begin
            m = $random(seed);
            m[ep] = en[0];
            wr(UIE_ADDR_MASK, m, 4'hF, UIE_RESP_OKAY);
            rd(UIE_ADDR_MASK, {28'h0, m[3:0]}, UIE_RESP_OKAY, "mask readback");
            fire(ep);
            rd(UIE_ADDR_STAT, 32'h1 << ep, UIE_RESP_OKAY, "status");
            chk("irq", exp_irq(m[3:0], 4'(1 << ep)), {31'h0, irq});
            wr(UIE_ADDR_CLR, 32'hF, 4'hF, UIE_RESP_OKAY);
            repeat (2) @(posedge clk);
            chk("irq cleared", 32'h0, {31'h0, irq});
         end
      end
      $display("test per_endpoint done");
      // Random mixes of events, then a partial clear
      for (int k = 0; k < 6; k++) begin
         m = $random(seed);
         s = $random(seed);
         c = $random(seed);
         wr(UIE_ADDR_MASK, m, 4'hF, UIE_RESP_OKAY);
         for (int ep = 0; ep < 4; ep++) if (s[ep]) fire(ep);
         chk("irq mix", exp_irq(m[3:0], s[3:0]), {31'h0, irq});
         wr(UIE_ADDR_CLR, c, 4'hF, UIE_RESP_OKAY);
         repeat (2) @(posedge clk);
         rd(UIE_ADDR_STAT, {28'h0, s[3:0] & ~c[3:0]}, UIE_RESP_OKAY, "status partial");
         chk("irq partial", exp_irq(m[3:0], s[3:0] & ~c[3:0]), {31'h0, irq});
         wr(UIE_ADDR_CLR, 32'hF, 4'hF, UIE_RESP_OKAY);
      end
      $display("test random_mix done");
      // Endpoint 1 event and its clear meet in one cycle: the set must win
      wr(UIE_ADDR_MASK, 32'hF, 4'hF, UIE_RESP_OKAY);
      fork
         begin
            ev(3'h1, 3'h0, 3'h0, 1'b0);
            ev(3'h0, 3'h0, 3'h1, 1'b0);
            ev(3'h0, 3'h0, 3'h0, 1'b0);
         end
         begin
            @(posedge clk);
            wr(UIE_ADDR_CLR, 32'h2, 4'hF, UIE_RESP_OKAY);
         end
      join
      repeat (2) @(posedge clk);
      rd(UIE_ADDR_STAT, 32'h2, UIE_RESP_OKAY, "status set wins");
      chk("irq set wins", 32'h1, {31'h0, irq});
      wr(UIE_ADDR_CLR, 32'hF, 4'hF, UIE_RESP_OKAY);
      $display("test set_wins done");
      // Faulty or unmatched traffic must leave status clear
      wr(UIE_ADDR_MASK, 32'hF, 4'hF, UIE_RESP_OKAY);
      ev(3'h1, 3'h1, 3'h0, 1'b0);
      ev(3'h0, 3'h0, 3'h1, 1'b0);
      ev(3'h1, 3'h0, 3'h0, 1'b0);
      ev(3'h0, 3'h1, 3'h1, 1'b0);
      ev(3'h2, 3'h0, 3'h0, 1'b0);
      ev(3'h0, 3'h2, 3'h0, 1'b0);
      ev(3'h0, 3'h0, 3'h2, 1'b0);
      ev(3'h0, 3'h0, 3'h4, 1'b0);
      ev(3'h4, 3'h0, 3'h4, 1'b0);
      ev(3'h0, 3'h0, 3'h0, 1'b0);
      repeat (4) @(posedge clk);
      rd(UIE_ADDR_STAT, 32'h0, UIE_RESP_OKAY, "status bad packets");
      chk("irq bad packets", 32'h0, {31'h0, irq});
      $display("test bad_packets done");
      // Reset in mid-run restores all enables and drops the pending arm
      wr(UIE_ADDR_MASK, 32'h5, 4'hF, UIE_RESP_OKAY);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(UIE_ADDR_MASK, {28'h0, UIE_MASK_RST}, UIE_RESP_OKAY, "mask mid reset");
      chk("irq mid reset", 32'h0, {31'h0, irq});
      ev(3'h0, 3'h0, 3'h4, 1'b0);
      ev(3'h0, 3'h0, 3'h0, 1'b0);
      repeat (4) @(posedge clk);
      rd(UIE_ADDR_STAT, 32'h0, UIE_RESP_OKAY, "status mid reset");
      $display("test mid_reset done");
      summarize();
   end
endmodule
`default_nettype wire
